// File: hdl/lmiu_hold_timer.sv
// hold timer: measures how long the interrupt output has been asserted
`timescale 1ns/10ps
module lmiu_hold_timer #(
  parameter int unsigned LIMIT = 320000,
  parameter int unsigned W     = $clog2(LIMIT + 2)
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  output logic      expired_o
);

  localparam logic [W-1:0] LIMIT_W = W'(LIMIT);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic         at_limit;

  // saturating count; cleared whenever counting stops or a fresh event restarts it
  assign at_limit = (count_q == LIMIT_W);
  assign count_d  = (!run_i || restart_i) ? '0 :
                    at_limit              ? count_q :
                                            count_q + W'(1);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // expiry only counts while running, so a stale count never releases the pin
  assign expired_o = run_i && !restart_i && at_limit;

endmodule : lmiu_hold_timer

// File: hdl/lmiu_pkg.sv
// package for the led matrix interrupt unit: map, fields, reset values, timing
package lmiu_pkg;

  // register byte addresses on the internal register port
  localparam logic [7:0] LMIU_ADDR_MASK      = 8'hf0;
  localparam logic [7:0] LMIU_ADDR_STATUS    = 8'hf1;

  // values after reset
  localparam logic [7:0] LMIU_MASK_RESET     = 8'h00;
  localparam logic [4:0] LMIU_STATUS_RESET   = 5'h00;
  localparam logic [7:0] LMIU_READ_ZERO      = 8'h00;

  // enable mask field positions
  localparam int unsigned LMIU_MASK_OPEN_BIT   = 0;
  localparam int unsigned LMIU_MASK_SHORT_BIT  = 1;
  localparam int unsigned LMIU_MASK_BREATH_BIT = 2;
  localparam int unsigned LMIU_MASK_ACLR_BIT   = 3;
  localparam int unsigned LMIU_MASK_USED       = 4;

  // status field positions
  localparam int unsigned LMIU_ST_OPEN_BIT   = 0;
  localparam int unsigned LMIU_ST_SHORT_BIT  = 1;
  localparam int unsigned LMIU_ST_B1_BIT     = 2;
  localparam int unsigned LMIU_ST_B2_BIT     = 3;
  localparam int unsigned LMIU_ST_B3_BIT     = 4;
  localparam int unsigned LMIU_ST_USED       = 5;

  // auto-clear hold time, a least time; the cycle count is the plain product, with no rounding term added
  localparam int unsigned LMIU_CLK_FREQ_HZ     = 40_000_000;
  localparam int unsigned LMIU_ACLR_TIME_US    = 8000;
  localparam int unsigned LMIU_ACLR_CYCLES     =
    (LMIU_ACLR_TIME_US * (LMIU_CLK_FREQ_HZ / 1_000_000) + 0);

  // events from the fault detectors and the breathing engine
  typedef struct packed {
    logic [2:0] breath_done;   // one-cycle pulse per mode, [0] is mode 1
    logic       short_det;     // level, high while a short exists
    logic       open_det;      // level, high while an open exists
  } lmiu_evt_t;

  // register port request, one transfer per cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmiu_reg_req_t;

endpackage : lmiu_pkg

// File: hdl/lmiu_top.sv
// led matrix interrupt unit: enable mask, status flags and interrupt pin drive
// Notes on behaviour
// R1 - with auto-clear on, pin releases itself after staying low over 8 ms
// R2 - with auto-clear off, pin stays low with no timed release
// R3 - mask bit 2 lets breathing-loop completion raise the interrupt
// R4 - mask bit 1 lets a detected short raise the interrupt
// R5 - mask bit 0 lets a detected open raise the interrupt
// R6 - mask resets to zero; bits 7 to 4 unused
// R7 - status: mode3 bit4, mode2 bit3, mode1 bit2, short bit1, open bit0
// R8 - all status flags read zero after reset until an event
// R9 - breathing flag reads one once its mode finished its loops
// R10 - open flag reads one once an open is detected, else zero
// R11 - short flag reads one once a short occurred, else zero
// R12 - host reads status by address write, repeated start, then read
// R13 - pin is low while any enabled status flag is set, except after an auto-clear release
`timescale 1ns/10ps
module lmiu_top
  import lmiu_pkg::*;
#(
  parameter int unsigned ACLR_CYCLES = LMIU_ACLR_CYCLES
) (
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire lmiu_reg_req_t reg_req_i,
  input  wire lmiu_evt_t     evt_i,
  output logic [7:0]         rd_data_o,
  output logic               rd_valid_o,
  output logic               irq_out_n_o
);

  // interrupt pin states, one-hot
  typedef enum logic [2:0] {
    LMIU_IRQ_IDLE     = 3'b001,
    LMIU_IRQ_ACTIVE   = 3'b010,
    LMIU_IRQ_RELEASED = 3'b100
  } lmiu_irq_state_t;

  logic [LMIU_MASK_USED-1:0] mask_q;
  logic [LMIU_MASK_USED-1:0] mask_d;
  logic [LMIU_ST_USED-1:0]   status_q;
  logic [LMIU_ST_USED-1:0]   status_d;
  logic [7:0]                rd_data_q;
  logic [7:0]                rd_data_d;
  logic                      rd_valid_q;
  lmiu_irq_state_t           state_q;
  lmiu_irq_state_t           state_d;

  // register port decode
  // one transfer per cycle; the serial decoder in front owns addressing and paging
  logic hit_mask;
  logic hit_status;
  logic mask_wr;
  logic status_rd;

  assign hit_mask   = (reg_req_i.addr == LMIU_ADDR_MASK);
  assign hit_status = (reg_req_i.addr == LMIU_ADDR_STATUS);
  assign mask_wr    = reg_req_i.wr && hit_mask;
  // a status read both returns the flags and clears them behind the answer
  assign status_rd  = reg_req_i.rd && !reg_req_i.wr && hit_status;

  // named mask fields
  logic open_irq_enable;
  logic short_irq_enable;
  logic breath_loop_irq_enable;
  logic auto_clear_enable;

  assign open_irq_enable        = mask_q[LMIU_MASK_OPEN_BIT];
  assign short_irq_enable       = mask_q[LMIU_MASK_SHORT_BIT];
  assign breath_loop_irq_enable = mask_q[LMIU_MASK_BREATH_BIT];
  assign auto_clear_enable      = mask_q[LMIU_MASK_ACLR_BIT];

  // only the low four bits are stored; the upper written bits are dropped
  assign mask_d = mask_wr ? reg_req_i.wdata[LMIU_MASK_USED-1:0] : mask_q; // see R6

  // mask clears on reset, leaving every source and auto-clear disabled
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q <= LMIU_MASK_RESET[LMIU_MASK_USED-1:0]; // see R6
    end else begin
      mask_q <= mask_d;
    end
  end

  // status set terms, laid out in the status bit order
  // fault inputs are levels and breathing inputs single-cycle pulses; both only set
  logic [LMIU_ST_USED-1:0] set_vec;
  logic [LMIU_ST_USED-1:0] clr_vec;
  logic                    open_flag;
  logic                    short_flag;
  logic                    breath_one_done;
  logic                    breath_two_done;
  logic                    breath_three_done;

  assign set_vec[LMIU_ST_OPEN_BIT]  = evt_i.open_det;       // see R10
  assign set_vec[LMIU_ST_SHORT_BIT] = evt_i.short_det;      // see R11
  assign set_vec[LMIU_ST_B1_BIT]    = evt_i.breath_done[0]; // see R9
  assign set_vec[LMIU_ST_B2_BIT]    = evt_i.breath_done[1]; // see R9
  assign set_vec[LMIU_ST_B3_BIT]    = evt_i.breath_done[2]; // see R9

  assign clr_vec = {LMIU_ST_USED{status_rd}};

  // set wins over the read clear, so an event in the read cycle survives;
  // a fault still present simply sets its flag again
  assign status_d = (status_q & ~clr_vec) | set_vec; // see R9 see R10 see R11

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= LMIU_STATUS_RESET; // see R8
    end else begin
      status_q <= status_d;
    end
  end

  assign open_flag         = status_q[LMIU_ST_OPEN_BIT];
  assign short_flag        = status_q[LMIU_ST_SHORT_BIT];
  assign breath_one_done   = status_q[LMIU_ST_B1_BIT];
  assign breath_two_done   = status_q[LMIU_ST_B2_BIT];
  assign breath_three_done = status_q[LMIU_ST_B3_BIT];

  // per-flag enables; all three breathing flags share one enable bit
  logic [LMIU_ST_USED-1:0] flag_en;
  logic                    pending;
  logic                    new_event;

  assign flag_en[LMIU_ST_OPEN_BIT]  = open_irq_enable;        // see R5
  assign flag_en[LMIU_ST_SHORT_BIT] = short_irq_enable;       // see R4
  assign flag_en[LMIU_ST_B1_BIT]    = breath_loop_irq_enable; // see R3
  assign flag_en[LMIU_ST_B2_BIT]    = breath_loop_irq_enable; // see R3
  assign flag_en[LMIU_ST_B3_BIT]    = breath_loop_irq_enable; // see R3

  // pending drives the pin; a new event is a flag rising from clear, so a
  // fault level that persists does not re-arm the pin after an auto-clear
  assign pending   = |(status_q & flag_en);             // see R13
  assign new_event = |(set_vec & ~status_q & flag_en);

  // hold timer runs only while the pin is low and auto-clear is on
  logic timer_run;
  logic timer_restart;
  logic timer_expired;

  assign timer_run     = (state_q == LMIU_IRQ_ACTIVE) && auto_clear_enable; // see R1 see R2
  assign timer_restart = new_event;

  // limitation: every newly rising enabled flag restarts the timer, so a burst of
  // fresh events keeps the pin low for longer than one hold time
  lmiu_hold_timer #(
    .LIMIT (ACLR_CYCLES)
  ) u_hold_timer (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .run_i     (timer_run),
    .restart_i (timer_restart),
    .expired_o (timer_expired)
  );

  // pin state machine; released state waits for a new event or for the flags
  // to be read away, it never re-asserts on its own
  always_comb begin
    state_d = state_q;
    case (state_q)
      LMIU_IRQ_IDLE: begin
        if (pending) begin
          state_d = LMIU_IRQ_ACTIVE; // see R13
        end
      end
      LMIU_IRQ_ACTIVE: begin
        if (!pending) begin
          state_d = LMIU_IRQ_IDLE; // see R13
        end else if (timer_expired) begin
          state_d = LMIU_IRQ_RELEASED; // see R1
        end
      end
      LMIU_IRQ_RELEASED: begin
        if (!pending) begin
          state_d = LMIU_IRQ_IDLE;
        end else if (new_event) begin
          state_d = LMIU_IRQ_ACTIVE;
        end
      end
      default: begin
        state_d = LMIU_IRQ_IDLE;
      end
    endcase
  end

  // idle after reset, so the pin starts released
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= LMIU_IRQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // pin low only in the active state, straight from the one-hot flop
  // trade-off: one extra cycle of latency buys a glitch-free pin
  assign irq_out_n_o = ~state_q[1]; // see R13 see R2

  // read answer: status with upper bits zero; the mask is write-only and
  // reads, like any unmapped address, as zero
  logic [7:0] status_word;

  assign status_word = {{(8 - LMIU_ST_USED){1'b0}}, breath_three_done, breath_two_done,
                        breath_one_done, short_flag, open_flag}; // see R7
  assign rd_data_d   = (reg_req_i.rd && hit_status) ? status_word : // see R12
                       reg_req_i.rd                 ? LMIU_READ_ZERO :
                                                      rd_data_q;

  // answer strobe follows every read, mapped or not, so the host never waits in vain
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_q  <= LMIU_READ_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= reg_req_i.rd;
    end
  end

  assign rd_data_o  = rd_data_q;
  assign rd_valid_o = rd_valid_q;

endmodule : lmiu_top

// File: verification/lmiu_host_model.sv
// host model: the microcontroller on the register port
`timescale 1ns/10ps
module lmiu_host_model
  import lmiu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output lmiu_reg_req_t   reg_req_o
);
  initial reg_req_o = '0;
  // one transfer held over its taking edge; idle fields inverted so stale values never help
  task automatic xfer(input logic wr, input logic [7:0] a, w, output logic [7:0] d);
    @(posedge clk_i);
    #2;
    reg_req_o = '{wr: wr, rd: !wr, addr: a, wdata: w};
    @(posedge clk_i);
    #2;
    d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx; // no strobe, no data
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~w};
  endtask : xfer
endmodule : lmiu_host_model

// File: verification/lmiu_top_properties.sv
// port checker for the led matrix interrupt unit
`timescale 1ns/10ps
module lmiu_checker
  import lmiu_pkg::*;
#(
  parameter int unsigned ACLR_CYCLES = LMIU_ACLR_CYCLES
) (
  input wire logic          clk_i,
  input wire logic          nrst_i,
  input wire lmiu_reg_req_t reg_req_i,
  input wire lmiu_evt_t     evt_i,
  input wire logic [7:0]    rd_data_o,
  input wire logic          rd_valid_o,
  input wire logic          irq_out_n_o
);
  logic [3:0]  mask_q;
  logic [19:0] low_q;
  wire         mask_wr = reg_req_i.wr && (reg_req_i.addr == LMIU_ADDR_MASK);
  // shadow of the write-only mask, since it cannot be read back
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_q <= 4'h0;
      low_q  <= 20'h0;
    end else begin
      mask_q <= mask_wr ? reg_req_i.wdata[3:0] : mask_q;
      low_q  <= irq_out_n_o ? 20'h0 : low_q + 20'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_stat_rd;
    reg_req_i.rd && (reg_req_i.addr == LMIU_ADDR_STATUS);
  endsequence
  property p_rd_answer; ##1 rd_valid_o == $past(reg_req_i.rd); endproperty
  property p_rd_zero; reg_req_i.rd && (reg_req_i.addr != LMIU_ADDR_STATUS) |=> rd_data_o == LMIU_READ_ZERO; endproperty
  property p_upper_zero; s_stat_rd |=> rd_data_o[7:5] == 3'h0; endproperty
  property p_open_flag; evt_i.open_det ##1 s_stat_rd |=> rd_data_o[LMIU_ST_OPEN_BIT]; endproperty
  property p_evt_flags;
    (evt_i[4:1] != 4'h0) ##1 s_stat_rd |=> (rd_data_o[4:1] & $past(evt_i[4:1], 2)) == $past(evt_i[4:1], 2);
  endproperty
  property p_src_irq;
    ((evt_i.open_det && mask_q[0]) || (evt_i.short_det && mask_q[1]) || ((|evt_i.breath_done) && mask_q[2]))
      && !mask_q[3] |-> ##2 !irq_out_n_o;
  endproperty
  property p_no_release;
    !irq_out_n_o && !mask_q[3] && !reg_req_i.rd && !reg_req_i.wr && !$past(reg_req_i.rd)
      && !$past(reg_req_i.wr) |=> !irq_out_n_o;
  endproperty
  property p_aclr_limit; mask_q[3] && !irq_out_n_o |-> low_q <= ACLR_CYCLES; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer strobe misplaced");
  a_rd_zero: assert property (p_rd_zero) else $error("non-status read not zero");
  a_upper_zero: assert property (p_upper_zero) else $error("status upper bits set");
  a_open_flag: assert property (p_open_flag) else $error("open flag missing");
  a_evt_flags: assert property (p_evt_flags) else $error("event flag missing");
  a_src_irq: assert property (p_src_irq) else $error("enabled source gave no interrupt");
  a_no_release: assert property (p_no_release) else $error("interrupt released by itself");
  a_aclr_limit: assert property (p_aclr_limit) else $error("auto-clear too late");
endmodule : lmiu_checker
bind lmiu_top lmiu_checker #(.ACLR_CYCLES(ACLR_CYCLES)) lmiu_checker_inst (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_req_i(reg_req_i), .evt_i(evt_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .irq_out_n_o(irq_out_n_o));

// File: verification/lmiu_top_test.sv
// testbench for the led matrix interrupt unit
`timescale 1ns/10ps
module lmiu_top_test;
  import lmiu_pkg::*;
  localparam int unsigned ACLR = 20; // short hold time keeps the run brief
  logic          clk_i = 1'b0;
  logic          nrst_i = 1'b0;
  lmiu_evt_t     evt_i = '0;
  lmiu_reg_req_t req;
  logic [7:0]    rd_data;
  logic          rd_valid;
  logic          irq_n;
  logic [7:0]    d;
  int            fails = 0;
  int            check_count = 0;
  int            n;
  int            mb;
  lmiu_top #(.ACLR_CYCLES(ACLR)) lmiu_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_req_i(req), .evt_i(evt_i),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .irq_out_n_o(irq_n));
  lmiu_host_model lmiu_host_model_inst (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .reg_req_o(req));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic check(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask : tick
  task automatic wr(input logic [7:0] a, w);
    lmiu_host_model_inst.xfer(1'b1, a, w, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, exp);
    lmiu_host_model_inst.xfer(1'b0, a, 8'h00, d);
    check(d, exp);
  endtask : rd_chk
  // hang guard, several times the expected length
  initial begin
    repeat (3000) @(posedge clk_i);
    fails++;
    test_done();
  end
  initial begin
    tick(12);
    nrst_i = 1'b1;
    check({7'h0, irq_n}, 8'h01);
    rd_chk(LMIU_ADDR_STATUS, 8'h00);
    rd_chk(LMIU_ADDR_MASK, LMIU_READ_ZERO);
    wr(LMIU_ADDR_STATUS, 8'hff);
    rd_chk(8'h00, 8'h00);
    rd_chk(LMIU_ADDR_STATUS, 8'h00);
    // event bit j lines up with status bit j; each source enabled, then masked
    for (int j = 0; j < 5; j++) begin
      mb = (j < 2) ? j : 2;
      wr(LMIU_ADDR_MASK, 8'h01 << mb);
      evt_i = lmiu_evt_t'(5'h01 << j);
      tick(1);
      evt_i = '0;
      tick(2);
      check({7'h0, irq_n}, 8'h00);
      tick(30);
      check({7'h0, irq_n}, 8'h00);
      rd_chk(LMIU_ADDR_STATUS, 8'h01 << j);
      tick(1);
      check({7'h0, irq_n}, 8'h01);
      wr(LMIU_ADDR_MASK, 8'h07 ^ (8'h01 << mb));
      evt_i = lmiu_evt_t'(5'h01 << j);
      fork
        rd_chk(LMIU_ADDR_STATUS, 8'h01 << j);
        begin
          tick(1);
          evt_i = '0;
        end
      join
      check({7'h0, irq_n}, 8'h01);
    end
    // auto-clear with a fault level that stays on past the release
    wr(LMIU_ADDR_MASK, 8'h09);
    evt_i.open_det = 1'b1;
    tick(2);
    n = 0;
    while (irq_n === 1'b0 && n < 100) begin
      n++;
      tick(1);
    end
    check(8'(n), 8'(ACLR + 1));
    tick(10);
    check({7'h0, irq_n}, 8'h01);
    rd_chk(LMIU_ADDR_STATUS, 8'h01);
    evt_i.open_det = 1'b0;
    rd_chk(LMIU_ADDR_STATUS, 8'h01);
    rd_chk(LMIU_ADDR_STATUS, 8'h00);
    // mid-run reset with a flag set and open enabled: both must come back cleared
    evt_i.open_det = 1'b1;
    tick(1);
    nrst_i = 1'b0;
    evt_i.open_det = 1'b0;
    tick(2);
    nrst_i = 1'b1;
    check({7'h0, irq_n}, 8'h01);
    rd_chk(LMIU_ADDR_STATUS, 8'h00);
    evt_i.open_det = 1'b1;
    tick(1);
    evt_i.open_det = 1'b0;
    tick(3);
    check({7'h0, irq_n}, 8'h01);
    rd_chk(LMIU_ADDR_STATUS, 8'h01);
    test_done();
  end
endmodule : lmiu_top_test
